//--- rtl/pic_defines.vh
/*
  Constants for the prioritized interrupt controller: source indices,
  vector addresses, acceptance sequence states.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PIC_DEFINES_VH
`define PIC_DEFINES_VH

// ----------------------------------------------------------------
// Source indices (ascending index = falling priority)
// ----------------------------------------------------------------
`define PIC_NSRC 16
`define PIC_SRC_EXT_A 4'h0
`define PIC_SRC_SCLSDA 4'h1
`define PIC_SRC_EXT_B 4'h2
`define PIC_SRC_EXT_C 4'h3
`define PIC_SRC_EXT_D 4'h4
`define PIC_SRC_I2C 4'h5
`define PIC_SRC_TMR_X 4'h6
`define PIC_SRC_TMR_Y 4'h7
`define PIC_SRC_TMR_1 4'h8
`define PIC_SRC_TMR_2 4'h9
`define PIC_SRC_SER_RX 4'ha
`define PIC_SRC_SER_TX 4'hb
`define PIC_SRC_CNT_A 4'hc
`define PIC_SRC_CNT_B 4'hd
`define PIC_SRC_ADC 4'he
`define PIC_SRC_BREAK 4'hf

// ----------------------------------------------------------------
// Vectors: low byte addresses; high byte is low plus one
// ----------------------------------------------------------------
`define PIC_VEC_RESET 16'hfffc
`define PIC_VEC_FIRST 16'hfffa
`define PIC_VEC_STEP 16'h0002
`define PIC_VEC_HI_OFS 16'h0001

// ----------------------------------------------------------------
// Acceptance sequence states (one-hot)
// ----------------------------------------------------------------
`define PIC_ST_IDLE 7'h01
`define PIC_ST_PUSH_PCH 7'h02
`define PIC_ST_PUSH_PCL 7'h04
`define PIC_ST_PUSH_PS 7'h08
`define PIC_ST_FETCH_LO 7'h10
`define PIC_ST_FETCH_HI 7'h20
`define PIC_ST_DONE 7'h40

`endif

//--- rtl/pic_edge_det.v
/*
  Edge detector for one external interrupt pin: two-stage synchroniser
  and rising/falling edge selection.
  Assumes the pin is asynchronous to clk_sys; one clock, sync reset.
*/
`timescale 1ns/1ps
`default_nettype none

module pic_edge_det (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Pin and selection
  input wire pin_in,
  input wire fall_sel,
  // One-cycle pulse on the selected edge
  output reg edge_pulse
);

  reg meta_r;
  reg sync_r;
  reg last_r;
  reg [2:0] arm_r;

  // ----------------------------------------------------------------
  // Synchroniser, then compare with previous sample
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (reset) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
      arm_r <= 3'h0;
      edge_pulse <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      last_r <= sync_r;
      // No pulse until both compare stages hold real pin samples after reset
      arm_r <= {arm_r[1:0], 1'b1};
      edge_pulse <= arm_r[2] & (fall_sel ? (last_r & ~sync_r) : (~last_r & sync_r));
    end
  end

endmodule // pic_edge_det

`default_nettype wire

//--- rtl/pic_ctrl.v
/*
  Prioritized interrupt controller: request latches, enables, global
  mask, fixed-priority choice, acceptance sequence with stack push and
  two-byte vector fetch.
  Assumes the core grants bus cycles with core_ack and returns vector
  bytes on vec_data in the cycle of core_ack.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pic_defines.vh"

module pic_ctrl (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // External pins
  input wire ext_pin_irq_a,
  input wire ext_pin_irq_b,
  input wire ext_pin_irq_c,
  input wire ext_pin_irq_d,
  input wire counter_pin_a,
  input wire counter_pin_b,
  input wire scl_in,
  input wire sda_in,
  // Edge and source selection (1 selects falling edge)
  input wire [5:0] edge_fall_sel,
  input wire sclsda_fall_sel,
  input wire sclsda_use_sda,
  // Internal event pulses
  input wire i2c_done,
  input wire [3:0] timer_underflow,
  input wire serial_mode,
  input wire ser_rx_done,
  input wire ser_tx_done,
  input wire ser_tx_empty,
  input wire ser_tx_on_empty,
  input wire adc_done,
  input wire software_break_op,
  // Software access to enables, latches and mask
  input wire [15:0] enable_wr_data,
  input wire enable_wr,
  input wire [15:0] request_clr,
  input wire mask_set,
  input wire mask_clr,
  // Core handshake
  input wire core_ack,
  input wire [7:0] vec_data,
  input wire [15:0] core_pc,
  input wire [7:0] core_ps,
  // Status and core drive
  output reg [15:0] request_r,
  output reg [15:0] enable_r,
  output reg mask_r,
  output reg busy_r,
  output reg [3:0] src_r,
  output reg bus_req_r,
  output reg bus_wr_r,
  output reg [15:0] bus_addr_r,
  output reg [7:0] bus_wdata_r,
  output reg stack_dec_r,
  output reg pc_load_r,
  output reg [15:0] pc_new_r,
  output reg reset_vec_r
);

  // ----------------------------------------------------------------
  // Local state
  // ----------------------------------------------------------------
  localparam [6:0] ST_IDLE = `PIC_ST_IDLE;
  localparam [6:0] ST_PUSH_PCH = `PIC_ST_PUSH_PCH;
  localparam [6:0] ST_PUSH_PCL = `PIC_ST_PUSH_PCL;
  localparam [6:0] ST_PUSH_PS = `PIC_ST_PUSH_PS;
  localparam [6:0] ST_FETCH_LO = `PIC_ST_FETCH_LO;
  localparam [6:0] ST_FETCH_HI = `PIC_ST_FETCH_HI;
  localparam [6:0] ST_DONE = `PIC_ST_DONE;

  reg [6:0] state_r;
  reg [6:0] state_nxt;
  reg [15:0] pc_save_r;
  reg [7:0] ps_save_r;
  reg [7:0] vec_lo_r;
  reg [15:0] vec_base_r;
  reg fresh_r;
  reg sclsda_pin_r;
  reg sclsda_sel_r;
  reg sclsda_fall_r;

  wire [5:0] pin_edge;
  wire sclsda_edge;
  reg [15:0] event_set;
  reg [15:0] qualified;
  reg any_q;
  reg [3:0] win;
  reg [15:0] accept_clr;

  // Low vector address of a source index
  function [15:0] vec_low;
    input [3:0] idx;
    begin
      vec_low = `PIC_VEC_FIRST - ({12'h000, idx} * `PIC_VEC_STEP);
    end
  endfunction

  // ----------------------------------------------------------------
  // Edge detection for the six pins and the line-edge source
  // ----------------------------------------------------------------
  wire [5:0] pins = {counter_pin_b, counter_pin_a, ext_pin_irq_d,
                     ext_pin_irq_c, ext_pin_irq_b, ext_pin_irq_a};
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_pin
      pic_edge_det u_det (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_in(pins[g]),
        .fall_sel(edge_fall_sel[g]),
        .edge_pulse(pin_edge[g])
      );
    end
  endgenerate

  // Line-edge source pin chosen by the selection bit
  always @(posedge clk_sys) begin
    if (reset) begin
      sclsda_pin_r <= sclsda_use_sda ? sda_in : scl_in; // No false edge at release
    end else begin
      sclsda_pin_r <= sclsda_use_sda ? sda_in : scl_in;
    end
  end

  pic_edge_det u_sclsda (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_in(sclsda_pin_r),
    .fall_sel(sclsda_fall_sel),
    .edge_pulse(sclsda_edge)
  );

  // Selection changes, remembered to raise a side-effect request
  always @(posedge clk_sys) begin
    if (reset) begin
      sclsda_sel_r <= sclsda_use_sda; // Live selection is no change
      sclsda_fall_r <= sclsda_fall_sel;
    end else begin
      sclsda_sel_r <= sclsda_use_sda;
      sclsda_fall_r <= sclsda_fall_sel;
    end
  end

  // ----------------------------------------------------------------
  // Event mapping onto request latch positions
  // ----------------------------------------------------------------
  always @* begin
    event_set = 16'h0000;
    event_set[`PIC_SRC_EXT_A] = pin_edge[0];
    event_set[`PIC_SRC_SCLSDA] = sclsda_edge |
      (sclsda_sel_r ^ sclsda_use_sda) | (sclsda_fall_r ^ sclsda_fall_sel);
    event_set[`PIC_SRC_EXT_B] = pin_edge[1];
    event_set[`PIC_SRC_EXT_C] = pin_edge[2];
    event_set[`PIC_SRC_EXT_D] = pin_edge[3];
    event_set[`PIC_SRC_I2C] = i2c_done;
    event_set[`PIC_SRC_TMR_X] = timer_underflow[0];
    event_set[`PIC_SRC_TMR_Y] = timer_underflow[1];
    event_set[`PIC_SRC_TMR_1] = timer_underflow[2];
    event_set[`PIC_SRC_TMR_2] = timer_underflow[3];
    event_set[`PIC_SRC_SER_RX] = serial_mode & ser_rx_done;
    event_set[`PIC_SRC_SER_TX] = serial_mode &
      (ser_tx_on_empty ? ser_tx_empty : ser_tx_done);
    event_set[`PIC_SRC_CNT_A] = pin_edge[4];
    event_set[`PIC_SRC_CNT_B] = pin_edge[5];
    event_set[`PIC_SRC_ADC] = adc_done;
    event_set[`PIC_SRC_BREAK] = software_break_op;
  end

  // ----------------------------------------------------------------
  // Qualification and fixed-priority choice
  // ----------------------------------------------------------------
  always @* begin : qual_blk
    integer i;
    qualified = request_r & enable_r & {16{~mask_r}};
    qualified[`PIC_SRC_BREAK] = request_r[`PIC_SRC_BREAK];
    any_q = |qualified;
    win = 4'h0;
    for (i = `PIC_NSRC - 1; i >= 0; i = i - 1) begin
      if (qualified[i]) begin
        win = i[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Enables, request latches and global mask
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (reset) begin
      enable_r <= 16'h0000;
      request_r <= 16'h0000;
      mask_r <= 1'b1;
    end else begin
      if (enable_wr) begin
        enable_r <= enable_wr_data;
      end
      // Set wins over clear; a latch holds until cleared
      request_r <= (request_r & ~request_clr & ~accept_clr) | event_set;
      if (state_r == ST_PUSH_PS && core_ack) begin
        mask_r <= 1'b1;
      end else if (mask_clr) begin
        mask_r <= 1'b0;
      end else if (mask_set) begin
        mask_r <= 1'b1;
      end
    end
  end

  // Accepted source cleared at acceptance; the reset fetch takes no latch
  always @* begin
    accept_clr = 16'h0000;
    if (state_r == ST_IDLE && any_q && !fresh_r) begin
      accept_clr[win] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Acceptance sequence: next state
  // ----------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (fresh_r || any_q) begin
          state_nxt = fresh_r ? ST_FETCH_LO : ST_PUSH_PCH;
        end
      end
      ST_PUSH_PCH: begin
        if (core_ack) begin
          state_nxt = ST_PUSH_PCL;
        end
      end
      ST_PUSH_PCL: begin
        if (core_ack) begin
          state_nxt = ST_PUSH_PS;
        end
      end
      ST_PUSH_PS: begin
        if (core_ack) begin
          state_nxt = ST_FETCH_LO;
        end
      end
      ST_FETCH_LO: begin
        if (core_ack) begin
          state_nxt = ST_FETCH_HI;
        end
      end
      ST_FETCH_HI: begin
        if (core_ack) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Acceptance sequence: registers and core drive
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (reset) begin
      state_r <= ST_IDLE;
      fresh_r <= 1'b1;
      pc_save_r <= 16'h0000;
      ps_save_r <= 8'h00;
      vec_lo_r <= 8'h00;
      vec_base_r <= `PIC_VEC_RESET;
      busy_r <= 1'b0;
      src_r <= 4'h0;
      bus_req_r <= 1'b0;
      bus_wr_r <= 1'b0;
      bus_addr_r <= 16'h0000;
      bus_wdata_r <= 8'h00;
      stack_dec_r <= 1'b0;
      pc_load_r <= 1'b0;
      pc_new_r <= 16'h0000;
      reset_vec_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      stack_dec_r <= 1'b0;
      pc_load_r <= 1'b0;
      case (state_nxt)
        ST_PUSH_PCH: begin
          bus_req_r <= 1'b1;
          bus_wr_r <= 1'b1;
          bus_wdata_r <= core_pc[15:8];
        end
        ST_PUSH_PCL: begin
          bus_req_r <= 1'b1;
          bus_wr_r <= 1'b1;
          bus_wdata_r <= pc_save_r[7:0];
        end
        ST_PUSH_PS: begin
          bus_req_r <= 1'b1;
          bus_wr_r <= 1'b1;
          bus_wdata_r <= ps_save_r;
        end
        ST_FETCH_LO: begin
          bus_req_r <= 1'b1;
          bus_wr_r <= 1'b0;
          bus_addr_r <= vec_base_r;
        end
        ST_FETCH_HI: begin
          bus_req_r <= 1'b1;
          bus_wr_r <= 1'b0;
          bus_addr_r <= vec_base_r + `PIC_VEC_HI_OFS;
        end
        default: begin
          bus_req_r <= 1'b0;
          bus_wr_r <= 1'b0;
        end
      endcase
      // Push steps each decrement the stack pointer
      if (core_ack && (state_r == ST_PUSH_PCH || state_r == ST_PUSH_PCL ||
                       state_r == ST_PUSH_PS)) begin
        stack_dec_r <= 1'b1;
      end
      if (state_r == ST_IDLE && state_nxt != ST_IDLE) begin
        busy_r <= 1'b1;
        fresh_r <= 1'b0;
        reset_vec_r <= fresh_r;
        pc_save_r <= core_pc;
        ps_save_r <= core_ps;
        src_r <= fresh_r ? 4'h0 : win;
        vec_base_r <= fresh_r ? `PIC_VEC_RESET : vec_low(win);
      end
      if (state_r == ST_FETCH_LO && core_ack) begin
        vec_lo_r <= vec_data;
      end
      if (state_r == ST_FETCH_HI && core_ack) begin
        pc_load_r <= 1'b1;
        pc_new_r <= {vec_data, vec_lo_r};
      end
      if (state_r == ST_DONE) begin
        busy_r <= 1'b0;
        reset_vec_r <= 1'b0;
      end
    end
  end

endmodule // pic_ctrl

`default_nettype wire

//--- tb/pic_core_model.sv
/*
  Core-side model for pic_ctrl: accepts stack pushes, answers vector
  fetches with the low address byte. Assumes clk_sys and sync reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pic_core_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Pacing: 1 adds wait cycles before each answer
  input wire logic slow,
  // Bus from the controller
  input wire logic bus_req_r,
  input wire logic bus_wr_r,
  input wire logic [15:0] bus_addr_r,
  input wire logic [7:0] bus_wdata_r,
  // Answers and record of pushed bytes
  output logic core_ack,
  output logic [7:0] vec_data,
  output logic [23:0] pushed
);
  logic [1:0] wait_r;
  // One ack per step; data line toggles when not answering
  always @(posedge clk_sys) begin
    if (reset) begin
      core_ack <= 1'b0;
      wait_r <= 2'h0;
      pushed <= 24'h0;
      vec_data <= 8'h00;
    end else if (bus_req_r && !core_ack && (!slow || wait_r == 2'h3)) begin
      core_ack <= 1'b1;
      wait_r <= 2'h0;
      vec_data <= bus_addr_r[7:0];
      if (bus_wr_r) begin
        pushed <= {pushed[15:0], bus_wdata_r};
      end
    end else begin
      core_ack <= 1'b0;
      vec_data <= ~vec_data;
      if (bus_req_r && !core_ack) begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule // pic_core_model
`default_nettype wire

//--- tb/pic_ctrl_chk.sv
/*
  Port checker for pic_ctrl, bound at the foot of this file.
  Assumes one clock and a sync active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pic_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Watched ports
  input wire logic core_ack,
  input wire logic [15:0] request_r,
  input wire logic [15:0] enable_r,
  input wire logic mask_r,
  input wire logic busy_r,
  input wire logic [3:0] src_r,
  input wire logic bus_req_r,
  input wire logic bus_wr_r,
  input wire logic [15:0] bus_addr_r,
  input wire logic stack_dec_r,
  input wire logic pc_load_r,
  input wire logic reset_vec_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic take;
  // Some request qualifies for service
  assign take = request_r[15] || (!mask_r && |(request_r & enable_r));
  // ----------------------------------------------------------------
  // Acceptance steps
  // ----------------------------------------------------------------
  sequence s_push_done;
    core_ack && bus_wr_r;
  endsequence
  sequence s_hi_fetch;
    core_ack && !bus_wr_r && bus_addr_r[0];
  endsequence
  chk_take_pending: assert property (!busy_r && !$past(reset) && take |=> busy_r)
    else $error("qualified request not taken");
  chk_hold_masked: assert property (!busy_r && !$past(reset) && !take |=> !busy_r)
    else $error("sequence started without a qualified request");
  chk_latch_cleared: assert property ($rose(busy_r) && !reset_vec_r |-> !request_r[src_r])
    else $error("accepted latch not cleared");
  chk_mask_at_end: assert property ($fell(busy_r) |-> mask_r)
    else $error("mask not set by acceptance");
  chk_push_dec: assert property (s_push_done |=> stack_dec_r)
    else $error("push ack without stack step");
  chk_vec_load: assert property (s_hi_fetch |=> pc_load_r)
    else $error("high vector byte not loaded");
  chk_vec_addr: assert property (bus_req_r && !bus_wr_r && !reset_vec_r
    |-> bus_addr_r[15:1] == 15'h7ffd - {11'h000, src_r})
    else $error("vector address wrong for source");
  chk_reset_addr: assert property (bus_req_r && reset_vec_r
    |-> !bus_wr_r && bus_addr_r[15:1] == 15'h7ffe)
    else $error("reset vector address wrong");
  chk_load_pulse: assert property (pc_load_r |=> !pc_load_r ##[0:1] !busy_r)
    else $error("load pulse too long or sequence not ended");
endmodule // pic_chk
bind pic_ctrl pic_chk u_chk (.clk_sys(clk_sys), .reset(reset), .core_ack(core_ack),
  .request_r(request_r), .enable_r(enable_r), .mask_r(mask_r), .busy_r(busy_r),
  .src_r(src_r), .bus_req_r(bus_req_r), .bus_wr_r(bus_wr_r), .bus_addr_r(bus_addr_r),
  .stack_dec_r(stack_dec_r), .pc_load_r(pc_load_r), .reset_vec_r(reset_vec_r));
`default_nettype wire

//--- tb/tb.sv
/*
  Testbench for pic_ctrl with the core model on its bus side.
  Assumes a 200 MHz clk_sys and sync active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys, reset, serial_mode, scl_in, sda_in, mask_set, mask_clr, enable_wr, slow;
  logic sel_sda, sel_fall, tx_empty, tx_on_empty;
  logic [5:0] pins, fall_sel;
  logic [15:0] ev, en_d, clr, core_pc;
  logic [7:0] core_ps;
  wire logic [15:0] request_r, enable_r, bus_addr_r, pc_new_r;
  wire logic [7:0] bus_wdata_r, vec_data;
  wire logic [23:0] pushed;
  wire logic [3:0] src_r;
  wire logic mask_r, busy_r, bus_req_r, bus_wr_r, stack_dec_r, pc_load_r, reset_vec_r, core_ack;
  int n_fail, checks_done;
  // Device under test; event bit n feeds latch n for n = 5 to 11, 14 and 15
  pic_ctrl dut (.clk_sys(clk_sys), .reset(reset), .ext_pin_irq_a(pins[0]),
    .ext_pin_irq_b(pins[1]), .ext_pin_irq_c(pins[2]), .ext_pin_irq_d(pins[3]),
    .counter_pin_a(pins[4]), .counter_pin_b(pins[5]), .scl_in(scl_in), .sda_in(sda_in),
    .edge_fall_sel(fall_sel), .sclsda_fall_sel(sel_fall), .sclsda_use_sda(sel_sda),
    .i2c_done(ev[5]), .timer_underflow(ev[9:6]), .serial_mode(serial_mode),
    .ser_rx_done(ev[10]), .ser_tx_done(ev[11]), .ser_tx_empty(tx_empty),
    .ser_tx_on_empty(tx_on_empty),
    .adc_done(ev[14]), .software_break_op(ev[15]), .enable_wr_data(en_d),
    .enable_wr(enable_wr), .request_clr(clr), .mask_set(mask_set), .mask_clr(mask_clr),
    .core_ack(core_ack), .vec_data(vec_data), .core_pc(core_pc), .core_ps(core_ps),
    .request_r(request_r), .enable_r(enable_r), .mask_r(mask_r), .busy_r(busy_r),
    .src_r(src_r), .bus_req_r(bus_req_r), .bus_wr_r(bus_wr_r), .bus_addr_r(bus_addr_r),
    .bus_wdata_r(bus_wdata_r), .stack_dec_r(stack_dec_r), .pc_load_r(pc_load_r),
    .pc_new_r(pc_new_r), .reset_vec_r(reset_vec_r));
  pic_core_model core (.clk_sys(clk_sys), .reset(reset), .slow(slow), .bus_req_r(bus_req_r),
    .bus_wr_r(bus_wr_r), .bus_addr_r(bus_addr_r), .bus_wdata_r(bus_wdata_r),
    .core_ack(core_ack), .vec_data(vec_data), .pushed(pushed));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task sw(input logic w, input logic [15:0] d, input logic [15:0] c, input logic ms,
          input logic mc);
    @(posedge clk_sys);
    enable_wr <= w;
    en_d <= d;
    clr <= c;
    mask_set <= ms;
    mask_clr <= mc;
    @(posedge clk_sys);
    enable_wr <= 1'b0;
    clr <= 16'h0;
    mask_set <= 1'b0;
    mask_clr <= 1'b0;
  endtask
  task fire(input logic [15:0] m);
    @(posedge clk_sys);
    ev <= m;
    @(posedge clk_sys);
    ev <= 16'h0;
  endtask
  task wait_load;
    for (int i = 0; i < 200 && pc_load_r !== 1'b1; i++) idle(1);
  endtask
  // Wait for one acceptance of source k and check its effects
  task accept(input logic [3:0] k);
    logic [15:0] lo;
    lo = 16'hfffa - {11'h000, k, 1'b0};
    wait_load;
    chk(src_r, k);
    chk(pc_new_r, {lo[7:0] + 8'h01, lo[7:0]});
    chk(pushed, {core_pc, core_ps});
    chk(mask_r, 1'b1);
    chk(request_r[k], 1'b0);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Watchdog
  initial begin
    #(5 * 20000);
    n_fail++;
    conclude;
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1; pins = 6'h30; fall_sel = 6'h30; scl_in = 1'b0; sda_in = 1'b1;
    ev = 16'h0; en_d = 16'h0; clr = 16'h0; enable_wr = 1'b0; mask_set = 1'b0;
    mask_clr = 1'b0; serial_mode = 1'b0; slow = 1'b0; core_pc = 16'hb3c1; core_ps = 8'h6e;
    sel_sda = 1'b0; sel_fall = 1'b0; tx_empty = 1'b0; tx_on_empty = 1'b0;
    n_fail = 0; checks_done = 0;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    idle(1);
    chk({request_r, mask_r}, 17'h00001);
    wait_load;
    chk(pc_new_r, 16'hfdfc);
    $display("test reset done");
    sw(1'b1, 16'h5a5a, 16'h0, 1'b0, 1'b0);
    idle(1);
    chk(enable_r, 16'h5a5a);
    sw(1'b1, 16'h5fff, 16'h0, 1'b0, 1'b0);
    idle(1);
    chk(enable_r, 16'h5fff);
    fire(16'h0400);
    idle(3);
    chk(request_r, 16'h0);
    @(posedge clk_sys) serial_mode <= 1'b1;
    fire(16'h4fe0);
    @(posedge clk_sys);
    pins <= 6'h0f;
    scl_in <= 1'b1;
    idle(8);
    chk(request_r, 16'h7fff);
    chk(busy_r, 1'b0);
    sw(1'b0, 16'h0, 16'h4000, 1'b0, 1'b0);
    idle(1);
    chk(request_r, 16'h3fff);
    for (int k = 0; k < 13; k++) begin
      sw(1'b0, 16'h0, 16'h0, 1'b0, 1'b1);
      accept(k[3:0]);
    end
    sw(1'b0, 16'h0, 16'h0, 1'b0, 1'b1);
    idle(10);
    chk({busy_r, request_r}, 17'h02000);
    sw(1'b1, 16'h7fff, 16'h0, 1'b0, 1'b1);
    accept(4'hd);
    $display("test priority done");
    @(posedge clk_sys) slow <= 1'b1;
    sw(1'b0, 16'h0, 16'h0, 1'b1, 1'b0);
    fire(16'h8000);
    accept(4'hf);
    $display("test break done");
    @(posedge clk_sys) pins <= 6'h0e;
    idle(6);
    chk(request_r[0], 1'b0);
    @(posedge clk_sys) pins <= 6'h0f;
    idle(6);
    chk(request_r[0], 1'b1);
    sw(1'b0, 16'h0, 16'h0001, 1'b0, 1'b0);
    idle(6);
    chk(request_r[0], 1'b0);
    $display("test pin edge done");
    sw(1'b1, 16'h7ffd, 16'h0, 1'b0, 1'b0);
    @(posedge clk_sys) sel_sda <= 1'b1;
    idle(2);
    chk(request_r[1], 1'b1);
    sw(1'b0, 16'h0, 16'h0002, 1'b0, 1'b0);
    sw(1'b1, 16'h7fff, 16'h0, 1'b0, 1'b0);
    idle(1);
    chk(request_r[1], 1'b0);
    @(posedge clk_sys) sel_fall <= 1'b1;
    idle(2);
    chk(request_r[1], 1'b1);
    $display("test selection change done");
    @(posedge clk_sys) tx_on_empty <= 1'b1;
    fire(16'h0800);
    idle(2);
    chk(request_r[11], 1'b0);
    @(posedge clk_sys) tx_empty <= 1'b1;
    @(posedge clk_sys) tx_empty <= 1'b0;
    idle(2);
    chk(request_r[11], 1'b1);
    $display("test serial source done");
    @(posedge clk_sys) reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    idle(1);
    chk({request_r, mask_r}, 17'h00001);
    wait_load;
    chk(pc_new_r, 16'hfdfc);
    idle(2);
    chk(request_r, 16'h0000);
    $display("test second reset done");
    conclude;
  end
endmodule // tb
`default_nettype wire
